/* File: tb/sbs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sbs_host_model (
  // Clock
  input  wire logic                clock_i,
  // Pins toward the device
  output var sbs_pkg::sbs_ctrl_s   ctrl_o,
  output var logic        [16:0]   addr_o,
  output var logic        [35:0]   data_o,
  output var logic                 oe_n_o,
  output var logic                 sleep_o,
  output var logic                 order_n_o
);
  // Idle is a deselect with every write control inactive
  initial begin
    ctrl_o    = sbs_pkg::sbs_ctrl_s'(12'h97f);
    addr_o    = 17'h0;
    data_o    = 36'h0;
    oe_n_o    = 1'h0;
    sleep_o   = 1'h0;
    order_n_o = 1'h1;
  end

  // All pins change together just after the falling edge
  task automatic put(input logic [11:0] c, input logic [16:0] a, input logic [35:0] d,
                     input logic oe_n, input logic slp, input logic ord_n);
    @(negedge clock_i);
    ctrl_o    = sbs_pkg::sbs_ctrl_s'(c);
    addr_o    = a;
    // A released bus must not keep showing the last write
    data_o    = (!c[5] || (!c[4] && c[3:0] != 4'hf)) ? d : ~data_o;
    oe_n_o    = oe_n;
    sleep_o   = slp;
    order_n_o = ord_n;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [11:0] IDLE = 12'h97f;
  localparam logic [11:0] RD_P = 12'h4c0;
  localparam logic [11:0] WR_C = 12'h55f;
  localparam logic [11:0] BW_C = 12'h560;
  localparam logic [11:0] CN_W = 12'h99f;
  localparam logic [11:0] CN_R = 12'h5bf;
  localparam logic [11:0] SU_R = 12'h5ff;
  localparam logic [11:0] SU_W = 12'h5df;
  localparam logic [16:0] AD_A = 17'h1a5d;
  localparam logic [16:0] AD_B = 17'h0f22;

  logic clock_i, rst_i, oe_n, slp, ord_n;
  wire sbs_pkg::sbs_ctrl_s ctrl;
  wire logic [16:0] addr;
  wire logic [35:0] wdata, data_out;
  wire logic host_oe_n, host_sleep, host_ord_n, data_oe, stall, sleeping;
  int fails, checks_done;
  logic [35:0] mem [logic [16:0]];
  logic [16:0] base;
  logic [1:0] cnt;
  logic [3:0] pipe_rd;
  logic [3:0][35:0] pipe_d;

  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  sbs_host_model host_u (.clock_i(clock_i), .ctrl_o(ctrl), .addr_o(addr), .data_o(wdata),
    .oe_n_o(host_oe_n), .sleep_o(host_sleep), .order_n_o(host_ord_n));

  sbs_port dut_u (.clock_i(clock_i), .rst_i(rst_i), .enable_i(1'h1),
    .chip_select_primary_n_i(ctrl.chip_select_primary_n),
    .chip_select_high_active_i(ctrl.chip_select_high_active),
    .chip_select_secondary_n_i(ctrl.chip_select_secondary_n),
    .processor_address_strobe_n_i(ctrl.processor_address_strobe_n),
    .controller_address_strobe_n_i(ctrl.controller_address_strobe_n),
    .burst_step_n_i(ctrl.burst_step_n), .global_write_n_i(ctrl.global_write_n),
    .byte_write_gate_n_i(ctrl.byte_write_gate_n), .byte_lane_write_n_i(ctrl.byte_lane_write_n),
    .addr_i(addr), .data_i(wdata), .data_o(data_out), .data_oe_o(data_oe),
    .output_enable_n_i(host_oe_n), .sleep_request_i(host_sleep),
    .linear_order_select_n_i(host_ord_n), .write_stall_o(stall), .sleeping_o(sleeping));

  // ---------------------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One bus cycle; judge the cycle issued three calls ago, then reference decode
  task automatic cyc(input logic [11:0] c, input logic [16:0] a, input logic [35:0] d);
    logic [3:0] ln;
    logic [16:0] ad;
    logic act;
    host_u.put(c, a, d, oe_n, slp, ord_n);
    #1;
    check({35'h0, data_oe}, {35'h0, pipe_rd[2] & !oe_n});
    if (pipe_rd[2] && !oe_n) check(data_out, pipe_d[2]);
    check({35'h0, stall}, 36'h0);
    ln = !c[5] ? 4'hf : (!c[4] ? ~c[3:0] : 4'h0);
    act = 1'h0;
    if (!slp && !c[11] && c[10] && !c[9] && (!c[8] || !c[7])) begin
      base = a;
      cnt = 2'h0;
      act = 1'h1;
      if (!c[8]) ln = 4'h0;
    end else if (!slp && c[7] && (c[8] || c[11])) begin
      act = 1'h1;
      if (!c[6]) cnt = cnt + 2'h1;
    end
    ad = {base[16:2], ord_n ? base[1:0] ^ cnt : base[1:0] + cnt};
    for (int i = 0; i < 4; i++) if (act && ln[i]) mem[ad][9*i +: 9] = d[9*i +: 9];
    pipe_rd = {pipe_rd[2:0], act && ln == 4'h0};
    pipe_d = {pipe_d[2:0], (act && ln == 4'h0) ? mem[ad] : 36'h0};
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(IDLE, 17'h0, 36'h0);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_write;
    cyc(WR_C, AD_A, 36'h1_0203_0400);
    for (int k = 1; k < 4; k++) cyc(CN_W, 17'h0, 36'h1_0203_0400 + 36'(k));
    cyc(SU_W, 17'h0, 36'h5_5555_5555);
    // Reads are not driven while writes are queued, so let the queue drain
    idle(12);
    $display("write burst done");
  endtask

  task automatic t_read;
    cyc(RD_P, AD_A, 36'h0);
    repeat (4) cyc(CN_R, 17'h1fff0, 36'h0);
    cyc(SU_R, 17'h0, 36'h0);
    idle(2);
    oe_n = 1'h1;
    idle(2);
    oe_n = 1'h0;
    idle(2);
    $display("read burst done");
  endtask

  task automatic t_lanes;
    cyc(BW_C | 12'h000, AD_B, 36'h1_2345_6789);
    cyc(BW_C | 12'h00e, AD_B, 36'h0_0000_01ab);
    cyc(BW_C | 12'h005, AD_B, 36'hf_0ff0_0ff0);
    idle(12);
    cyc(BW_C | 12'h00f, AD_B, 36'h0);
    idle(4);
    $display("byte lanes done");
  endtask

  task automatic t_deselect;
    logic [11:0] rows [5];
    rows = '{12'h97f, 12'h6ff, 12'h0ff, 12'h77f, 12'h17f};
    cyc(RD_P, AD_A, 36'h0);
    foreach (rows[i]) cyc(rows[i], AD_B, 36'h0);
    idle(4);
    $display("deselect done");
  endtask

  task automatic t_linear;
    // Order changes only while deselected and quiet
    ord_n = 1'h0;
    idle(4);
    cyc(RD_P, AD_A, 36'h0);
    repeat (3) cyc(CN_R, 17'h0, 36'h0);
    idle(4);
    ord_n = 1'h1;
    idle(4);
    $display("linear order done");
  endtask

  task automatic t_sleep;
    int n;
    slp = 1'h1;
    n = 0;
    while (sleeping !== 1'h1 && n < 8) begin
      cyc(RD_P, AD_A, 36'h0);
      n++;
    end
    check({35'h0, sleeping}, 36'h1);
    if (n == 8) summarize();
    repeat (3) cyc(RD_P, AD_A, 36'h0);
    slp = 1'h0;
    idle(6);
    check({35'h0, sleeping}, 36'h0);
    cyc(RD_P, AD_A, 36'h0);
    idle(4);
    $display("sleep done");
  endtask

  initial begin
    rst_i = 1'h1;
    oe_n = 1'h0;
    slp = 1'h0;
    ord_n = 1'h1;
    fails = 0;
    checks_done = 0;
    pipe_rd = 4'h0;
    pipe_d = '0;
    base = 17'h0;
    cnt = 2'h0;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'h0;
    t_write();
    t_read();
    t_lanes();
    t_deselect();
    t_linear();
    t_sleep();
    summarize();
  end

  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire

/* File: verilog/sbs_array.sv */
`timescale 1ns/10ps
`default_nettype none
module sbs_array #(
  parameter int ADDR_W = 17,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  // Clock
  input  wire logic                      clock_i,
  input  wire logic                      enable_i,
  // Write port, per-lane strobes
  input  wire logic                      wr_en_i,
  input  wire logic [ADDR_W-1:0]         wr_addr_i,
  input  wire logic [LANES-1:0]          wr_lanes_i,
  input  wire logic [LANES*LANE_W-1:0]   wr_data_i,
  // Registered read port
  input  wire logic                      rd_en_i,
  input  wire logic [ADDR_W-1:0]         rd_addr_i,
  output logic      [LANES*LANE_W-1:0]   rd_data_o
);
  logic [LANE_W-1:0] mem_reg [LANES][2**ADDR_W];

  // Every selected lane is updated in the same edge
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge clock_i) begin
      if (enable_i && wr_en_i && wr_lanes_i[g]) begin
        mem_reg[g][wr_addr_i] <= wr_data_i[g*LANE_W +: LANE_W];
      end
      if (enable_i && rd_en_i) begin
        rd_data_o[g*LANE_W +: LANE_W] <= mem_reg[g][rd_addr_i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/sbs_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module sbs_fifo #(
  parameter int WIDTH = 57,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             enable_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0]      wr_ptr_reg;
  logic [PW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr_reg - rd_ptr_reg) != (PW+1)'(DEPTH);
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign push = enable_i && in_valid_i && in_ready_o;
  assign pop  = enable_i && out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg[PW-1:0]];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_ptr_reg - rd_ptr_reg) <= (PW+1)'(DEPTH))
    else $error("fifo occupancy above depth");
endmodule
`default_nettype wire

/* File: verilog/sbs_pkg.sv */
`default_nettype none
package sbs_pkg;
  // --------------------------------------------------------------------------
  // Geometry
  // --------------------------------------------------------------------------
  localparam int ADDR_W      = 17;
  localparam int DATA_W      = 36;
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int BURST_BITS  = 2;
  localparam int FIFO_DEPTH  = 8;

  localparam logic [1:0] BURST_ONE   = 2'h1;
  localparam logic [1:0] BURST_ZERO  = 2'h0;
  localparam logic [3:0] LANES_NONE  = 4'h0;
  localparam logic [3:0] LANES_ALL   = 4'hf;
  localparam logic [3:0] LANES_NARROW_MASK = 4'h3;

  // --------------------------------------------------------------------------
  // Cycle kinds decoded on each edge
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SBS_IDLE     = 3'b000,
    SBS_DESELECT = 3'b001,
    SBS_BEGIN    = 3'b010,
    SBS_CONTINUE = 3'b011,
    SBS_SUSPEND  = 3'b100,
    SBS_SLEEP    = 3'b101
  } sbs_cycle_e;

  // Control pins sampled together on one edge
  typedef struct packed {
    logic chip_select_primary_n;
    logic chip_select_high_active;
    logic chip_select_secondary_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_gate_n;
    logic [3:0] byte_lane_write_n;
  } sbs_ctrl_s;

  // Reset value of the sampled pins: controller strobe low with the primary select off
  localparam sbs_ctrl_s CTRL_DESELECT = sbs_ctrl_s'(12'hf7f);

  // Write request handed to the array through the FIFO
  typedef struct packed {
    logic [16:0] addr;
    logic [35:0] data;
    logic [3:0]  lanes;
  } sbs_wr_s;
endpackage
`default_nettype wire

/* File: verilog/sbs_port.sv */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Deselect and float data on the five deselect select/strobe combinations.
// - Selected with processor strobe low: read burst from external address.
// - Selected, processor strobe high, controller strobe low: begin burst, write if any write active.
// - Both strobes inactive, step low, no write: read next burst address.
// - Same continue conditions with a write: write next burst address.
// - Step high, no write: hold counter, read current address again.
// - Step high with write: write current unadvanced address.
// - Output enable gates read data asynchronously; ignored during writes.
// - Global write writes all lanes; else gated per-lane writes; else read.
// - Any combination of lane writes is applied together.
// - Narrow configuration ignores third and fourth lane controls.
// - Sleep request high suspends decode and floats data pins.
// - Order select high: interleaved order, start XOR count 0..3.
// - Order select low: linear order, start plus count modulo four.
// - After fourth address the counter wraps to the start address.
module sbs_port #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int LANES  = sbs_pkg::LANES,
  parameter int LANE_W = sbs_pkg::LANE_W,
  parameter bit NARROW = 1'b0,
  parameter int FIFO_DEPTH = sbs_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  input  wire logic                    enable_i,
  // Selects and strobes (pins)
  input  wire logic                    chip_select_primary_n_i,
  input  wire logic                    chip_select_high_active_i,
  input  wire logic                    chip_select_secondary_n_i,
  input  wire logic                    processor_address_strobe_n_i,
  input  wire logic                    controller_address_strobe_n_i,
  input  wire logic                    burst_step_n_i,
  // Write controls (pins)
  input  wire logic                    global_write_n_i,
  input  wire logic                    byte_write_gate_n_i,
  input  wire logic [LANES-1:0]        byte_lane_write_n_i,
  // Address and data (pins)
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [LANES*LANE_W-1:0] data_i,
  output logic      [LANES*LANE_W-1:0] data_o,
  output logic                         data_oe_o,
  // Asynchronous and static controls
  input  wire logic                    output_enable_n_i,
  input  wire logic                    sleep_request_i,
  input  wire logic                    linear_order_select_n_i,
  // Status
  output logic                         write_stall_o,
  output logic                         sleeping_o
);
  localparam int DW = LANES * LANE_W;
  localparam int FW = $bits(sbs_pkg::sbs_wr_s);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  sbs_pkg::sbs_ctrl_s ctrl_meta_reg;
  sbs_pkg::sbs_ctrl_s ctrl_reg;
  logic [ADDR_W-1:0]  addr_meta_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [DW-1:0]      din_meta_reg;
  logic [DW-1:0]      din_reg;
  logic [1:0]         misc_meta_reg;
  logic [1:0]         misc_reg;
  logic               sleep_req;
  logic               order_interleave;
  logic               oe_req;
  sbs_pkg::sbs_ctrl_s ctrl_pins;

  always_comb begin
    ctrl_pins.chip_select_primary_n       = chip_select_primary_n_i;
    ctrl_pins.chip_select_high_active     = chip_select_high_active_i;
    ctrl_pins.chip_select_secondary_n     = chip_select_secondary_n_i;
    ctrl_pins.processor_address_strobe_n  = processor_address_strobe_n_i;
    ctrl_pins.controller_address_strobe_n = controller_address_strobe_n_i;
    ctrl_pins.burst_step_n                = burst_step_n_i;
    ctrl_pins.global_write_n              = global_write_n_i;
    ctrl_pins.byte_write_gate_n           = byte_write_gate_n_i;
    ctrl_pins.byte_lane_write_n           = byte_lane_write_n_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      // All ones would decode as a suspended read and drive data after reset
      ctrl_meta_reg <= sbs_pkg::CTRL_DESELECT;
      ctrl_reg      <= sbs_pkg::CTRL_DESELECT;
      addr_meta_reg <= '0;
      addr_reg      <= '0;
      din_meta_reg  <= '0;
      din_reg       <= '0;
      misc_meta_reg <= '0;
      misc_reg      <= '0;
    end else if (enable_i) begin
      ctrl_meta_reg <= ctrl_pins;
      ctrl_reg      <= ctrl_meta_reg;
      addr_meta_reg <= addr_i;
      addr_reg      <= addr_meta_reg;
      din_meta_reg  <= data_i;
      din_reg       <= din_meta_reg;
      misc_meta_reg <= {sleep_request_i, linear_order_select_n_i};
      misc_reg      <= misc_meta_reg;
    end
  end

  assign sleep_req        = misc_reg[1];
  assign order_interleave = misc_reg[0];
  // Output enable is combinational on the pin so it acts without a clock edge
  assign oe_req           = ~output_enable_n_i;

  // --------------------------------------------------------------------------
  // Write lane decode
  // --------------------------------------------------------------------------
  logic [LANES-1:0] lane_mask;
  logic [LANES-1:0] lanes_wr;
  logic             wr_any;

  assign lane_mask = NARROW ? LANES'(sbs_pkg::LANES_NARROW_MASK)
                            : LANES'(sbs_pkg::LANES_ALL);
  always_comb begin
    if (!ctrl_reg.global_write_n) begin
      lanes_wr = lane_mask;
    end else if (!ctrl_reg.byte_write_gate_n) begin
      lanes_wr = ~ctrl_reg.byte_lane_write_n & lane_mask;
    end else begin
      lanes_wr = '0;
    end
  end
  assign wr_any = |lanes_wr;

  // --------------------------------------------------------------------------
  // Cycle decode
  // --------------------------------------------------------------------------
  sbs_pkg::sbs_cycle_e cycle;
  logic selected;
  logic deselect;
  logic begin_read_p;
  logic begin_c;
  logic cont;

  assign selected = !ctrl_reg.chip_select_primary_n && ctrl_reg.chip_select_high_active
                    && !ctrl_reg.chip_select_secondary_n;
  assign deselect = (ctrl_reg.chip_select_primary_n && !ctrl_reg.controller_address_strobe_n)
    || (!ctrl_reg.chip_select_primary_n && !selected
        && (!ctrl_reg.processor_address_strobe_n
            || !ctrl_reg.controller_address_strobe_n));
  assign begin_read_p = selected && !ctrl_reg.processor_address_strobe_n;
  assign begin_c = selected && ctrl_reg.processor_address_strobe_n
                   && !ctrl_reg.controller_address_strobe_n;
  assign cont = ctrl_reg.controller_address_strobe_n
                && (ctrl_reg.processor_address_strobe_n || ctrl_reg.chip_select_primary_n);

  always_comb begin
    if (sleep_req) begin
      cycle = sbs_pkg::SBS_SLEEP;
    end else if (deselect) begin
      cycle = sbs_pkg::SBS_DESELECT;
    end else if (begin_read_p || begin_c) begin
      cycle = sbs_pkg::SBS_BEGIN;
    end else if (cont && !ctrl_reg.burst_step_n) begin
      cycle = sbs_pkg::SBS_CONTINUE;
    end else if (cont) begin
      cycle = sbs_pkg::SBS_SUSPEND;
    end else begin
      cycle = sbs_pkg::SBS_IDLE;
    end
  end

  // --------------------------------------------------------------------------
  // Burst address counter
  // --------------------------------------------------------------------------
  logic [ADDR_W-1:0] base_reg;
  logic [1:0]        count_reg;
  logic [1:0]        low_bits;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [1:0]        count_next;

  assign count_next = count_reg + sbs_pkg::BURST_ONE;
  assign low_bits = order_interleave
    ? (base_reg[1:0] ^ count_reg)
    : (base_reg[1:0] + count_reg);
  assign cur_addr = {base_reg[ADDR_W-1:2], low_bits};
  assign next_addr = {base_reg[ADDR_W-1:2],
                      order_interleave ? (base_reg[1:0] ^ count_next)
                                       : (base_reg[1:0] + count_next)};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      base_reg       <= '0;
      count_reg      <= sbs_pkg::BURST_ZERO;
    end else if (enable_i) begin
      case (cycle)
        sbs_pkg::SBS_BEGIN: begin
          base_reg       <= addr_reg;
          count_reg      <= sbs_pkg::BURST_ZERO;
        end
        sbs_pkg::SBS_CONTINUE: begin
          count_reg <= count_next;
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Access selection
  // --------------------------------------------------------------------------
  logic              acc_read;
  logic              acc_write;
  logic [ADDR_W-1:0] acc_addr;
  logic [LANES-1:0]  acc_lanes;

  always_comb begin
    acc_read  = 1'b0;
    acc_write = 1'b0;
    acc_addr  = cur_addr;
    acc_lanes = '0;
    case (cycle)
      sbs_pkg::SBS_BEGIN: begin
        acc_addr = addr_reg;
        if (begin_c && wr_any) begin
          acc_write = 1'b1;
          acc_lanes = lanes_wr;
        end else begin
          acc_read = 1'b1;
        end
      end
      sbs_pkg::SBS_CONTINUE: begin
        acc_addr  = next_addr;
        acc_write = wr_any;
        acc_read  = !wr_any;
        acc_lanes = lanes_wr;
      end
      sbs_pkg::SBS_SUSPEND: begin
        acc_addr  = cur_addr;
        acc_write = wr_any;
        acc_read  = !wr_any;
        acc_lanes = lanes_wr;
      end
      default: begin
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Write buffer and array
  // --------------------------------------------------------------------------
  sbs_pkg::sbs_wr_s wr_req;
  sbs_pkg::sbs_wr_s wr_head;
  logic             wr_ready;
  logic             wr_valid;
  logic [FW-1:0]    wr_head_bits;
  logic             arr_rd;

  always_comb begin
    wr_req = '0;
    wr_req.addr  = 17'(acc_addr);
    wr_req.data  = 36'(din_reg);
    wr_req.lanes = 4'(acc_lanes);
  end
  assign wr_head = sbs_pkg::sbs_wr_s'(wr_head_bits);
  // A read is not driven while writes are queued, and is not retried, so it never shows stale data
  assign arr_rd = acc_read && !wr_valid;
  assign write_stall_o = !wr_ready;

  sbs_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .enable_i    (enable_i),
    .in_valid_i  (acc_write),
    .in_ready_o  (wr_ready),
    .in_data_i   (FW'(wr_req)),
    .out_valid_o (wr_valid),
    .out_ready_i (!acc_read),
    .out_data_o  (wr_head_bits)
  );

  logic [DW-1:0] arr_q;

  sbs_array #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_array (
    .clock_i    (clock_i),
    .enable_i   (enable_i),
    .wr_en_i    (wr_valid && !acc_read),
    .wr_addr_i  (ADDR_W'(wr_head.addr)),
    .wr_lanes_i (LANES'(wr_head.lanes)),
    .wr_data_i  (DW'(wr_head.data)),
    .rd_en_i    (acc_read),
    .rd_addr_i  (acc_addr),
    .rd_data_o  (arr_q)
  );

  // --------------------------------------------------------------------------
  // Output pipeline and drive
  // --------------------------------------------------------------------------
  logic read_out_reg;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      read_out_reg <= 1'b0;
    end else if (enable_i) begin
      read_out_reg <= arr_rd;
    end
  end

  assign data_o     = arr_q;
  assign data_oe_o  = read_out_reg && oe_req && !sleep_req;
  assign sleeping_o = sleep_req;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_begin_read;
    cycle == sbs_pkg::SBS_BEGIN && acc_read && !wr_valid;
  endsequence

  AST_DESELECT_FLOAT: assert property (@(posedge clock_i) disable iff (rst_i)
    enable_i && cycle == sbs_pkg::SBS_DESELECT |=> !data_oe_o)
    else $error("data driven after deselect");
  AST_PADS_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    selected && !ctrl_reg.processor_address_strobe_n && !sleep_req |-> !acc_write)
    else $error("write on processor strobe");
  AST_BEGIN_ADDR: assert property (@(posedge clock_i) disable iff (rst_i)
    enable_i && cycle == sbs_pkg::SBS_BEGIN |=> base_reg == $past(addr_reg))
    else $error("burst base not captured");
  AST_CONT_STEP: assert property (@(posedge clock_i) disable iff (rst_i)
    enable_i && cycle == sbs_pkg::SBS_CONTINUE |=> count_reg == $past(count_reg) + 2'h1)
    else $error("counter not advanced");
  AST_SUSPEND_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    enable_i && cycle == sbs_pkg::SBS_SUSPEND |=> $stable(count_reg))
    else $error("counter moved in suspend");
  AST_GW_ALL: assert property (@(posedge clock_i) disable iff (rst_i)
    !ctrl_reg.global_write_n |-> lanes_wr == lane_mask)
    else $error("global write missed a lane");
  AST_NARROW: assert property (@(posedge clock_i) disable iff (rst_i)
    NARROW |-> lanes_wr[LANES-1:2] == '0)
    else $error("narrow lane written");
  AST_SLEEP_FLOAT: assert property (@(posedge clock_i) disable iff (rst_i)
    sleep_req |-> !data_oe_o && !acc_read && !acc_write)
    else $error("activity during sleep");
  AST_PIPE: assert property (@(posedge clock_i) disable iff (rst_i)
    (enable_i and s_begin_read) ##1 (oe_req && !sleep_req) |-> data_oe_o)
    else $error("read data not driven next cycle");
  AST_WRAP: assert property (@(posedge clock_i) disable iff (rst_i)
    enable_i && cycle == sbs_pkg::SBS_CONTINUE && count_reg == 2'h3 |=> low_bits
      == base_reg[1:0])
    else $error("burst did not wrap");
  AST_UPPER: assert property (@(posedge clock_i) disable iff (rst_i)
    cur_addr[ADDR_W-1:2] == base_reg[ADDR_W-1:2])
    else $error("upper address changed");
endmodule
`default_nettype wire
